// *** logic/trig_pkg.sv ***
// Constants, register map and helpers for the edge trigger controller.
// Assumes a 125 MHz system clock.
`default_nettype none
package trig_pkg;
    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int CLK_NS = 8;
    localparam int FREERUN_US = 400;
    localparam int FREERUN_CYCLES = FREERUN_US * 1000 / CLK_NS;
    localparam int INT_MAX_NS = 60_000_000;
    localparam int INT_MAX_CYCLES = INT_MAX_NS / CLK_NS;
    localparam int HOLD_MIN_NS = 1000;
    localparam int HOLD_MIN_CYCLES = (HOLD_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam longint HOLD_MAX_NS = 64'd15_110_000_000;
    localparam int HOLD_MAX_CYCLES = int'(HOLD_MAX_NS / CLK_NS);
    localparam int THR_MAX_MV = 1000;
    localparam int THR_COARSE_MV = 10;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] THRESH_OFS = 12'h004;
    localparam logic [11:0] RATE_OFS = 12'h008;
    localparam logic [11:0] HOLDOFF_OFS = 12'h00C;
    localparam logic [11:0] STATUS_OFS = 12'h010;
    localparam int CTRL_RUN = 0;
    localparam int CTRL_SRC = 1;
    localparam int CTRL_SLOPE_NEG = 4;
    localparam int CTRL_HIGH_SENS = 5;
    localparam int CTRL_TRIGGERED = 6;
    localparam int CTRL_HOLD_EVT = 7;
    localparam int CTRL_FINE = 8;
    localparam int CTRL_AC = 9;
    localparam int CTRL_REJ = 10;
    localparam logic [11:0] CTRL_RST = 12'h000;
    localparam logic [10:0] THRESH_RST = 11'h000;
    localparam logic [23:0] RATE_RST = 24'h000002;
    localparam logic [31:0] HOLDOFF_RST = 32'h000000FA;
    localparam int STAT_CNT = 16;

    typedef enum logic [2:0] {
        SRC_EXT_DIRECT, SRC_EXT_PRESCALE, SRC_CH1, SRC_CH2, SRC_INT_CLOCK, SRC_RECOVERED
    } src_type;

    typedef enum logic [1:0] {
        REJ_NONE, REJ_LOW_FREQ, REJ_HIGH_FREQ
    } reject_type;

    // Coarse 1-2-5 code: [1:0] mantissa 1/2/5, [5:2] decade; result in ns
    function automatic logic [39:0] coarse_ns(input logic [5:0] code);
        logic [39:0] v;
        v = (code[1:0] == 2'h0) ? 40'h1 : (code[1:0] == 2'h1) ? 40'h2 : 40'h5;
        for (int i = 0; i < 10; i++)
        begin
            if (i < int'(code[5:2]))
            begin
                v = v * 40'hA;
            end
        end
        return v;
    endfunction
endpackage
`default_nettype wire

// *** logic/sync2.sv ***
// Two-stage synchroniser for a bus of independent level inputs.
// Assumes each bit is a slow level; no word coherence across bits.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= '0;
            q <= '0;
        end
        else
        begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// *** logic/interval_timer.sv ***
// Down counter that ticks a set number of cycles after start.
// Repeat mode reloads on each tick; dropping enable stops it at once.
`timescale 1ns/1ps
`default_nettype none
module interval_timer #(
    parameter int W = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic start,
    input wire logic repeat_en,
    input wire logic [W-1:0] period,
    output logic tick,
    output logic busy
);
    logic [W-1:0] cnt_ff, nxt_cnt;
    logic nxt_tick, nxt_busy;

    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_tick = 1'b0;
        nxt_busy = busy;
        if (!enable)
        begin
            nxt_busy = 1'b0;
        end
        else if (start)
        begin
            nxt_cnt = period;
            nxt_busy = 1'b1;
        end
        else if (busy)
        begin
            if (cnt_ff <= W'(1))
            begin
                nxt_tick = 1'b1;
                nxt_cnt = period;
                nxt_busy = repeat_en;
            end
            else
            begin
                nxt_cnt = cnt_ff - W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= '0;
            tick <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            tick <= nxt_tick;
            busy <= nxt_busy;
        end
    end
endmodule
`default_nettype wire

// *** logic/edge_trigger_controller.sv ***
// Edge trigger controller: source select, edge qualification, internal
// clock, holdoff and freerun/triggered control behind an AHB-Lite slave.
// Assumes comparator and pulse inputs are asynchronous to hclk.
//
// Notes on behaviour
// - Source codes beyond the six listed are refused; no channel 3 or 4.
// - Six sources: external direct, prescaled, channel 1, 2, internal, recovered.
// - Internal period 8 ns to 60 ms, 1-2-5 coarse codes or 4 ns fine.
// - Internal period only matters while the internal clock is the source.
// - Internal source: step pulse and trigger leave on the same edge.
// - Threshold spans -1 V to 1 V, 10 mV coarse or 1 mV fine.
// - Threshold, slope and hysteresis act only for direct sources.
// - Positive slope accepts upward passes, negative slope downward passes.
// - Above threshold is high, below threshold is low.
// - Normal hysteresis: re-arm only after the arming level is crossed.
// - High sensitivity: no arming needed before an accepted crossing.
// - Freerun self-triggers after 400 us without a real trigger.
// - Triggered mode never self-triggers.
// - Coupling and rejection reach the front end only for channel sources.
// - After each trigger the path is held off by time or event count.
// - Event holdoff counts only met trigger conditions.
// - Event count restarts per trigger; trigger on the event after count.
// - Holdoff time 1 us to 15.11 s, coarse 1-2-5 or 4 ns fine.
//
// Chosen here: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module edge_trigger_controller
    import trig_pkg::*;
#(
    parameter bit HAS_RECOVERY = 1'b1,
    parameter int FREERUN_CNT = FREERUN_CYCLES,
    parameter int INT_MAX_CNT = INT_MAX_CYCLES,
    parameter int HOLD_MAX_CNT = HOLD_MAX_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [2:0] cmp_level,
    input wire logic [2:0] cmp_arm,
    input wire logic prescale_in,
    input wire logic recovered_in,
    output logic trig_pulse_ff,
    output logic step_pulse_ff,
    output logic [10:0] threshold_mv_ff,
    output logic slope_neg_ff,
    output logic hyst_on_ff,
    output logic coupling_ac_ff,
    output logic [1:0] reject_ff
);
    // ----------------------------------------
    // Register file
    // ----------------------------------------
    logic [11:0] ctrl_ff, nxt_ctrl;
    logic [10:0] thresh_ff, nxt_thresh;
    logic [23:0] rate_ff, nxt_rate;
    logic [31:0] hold_ff, nxt_hold;
    logic [31:0] nxt_rdata;
    logic wr_ff, nxt_wr;
    logic [11:0] wa_ff, nxt_wa;
    logic [15:0] tcount_ff;
    logic self_last_ff;
    logic ahb_go;
    src_type src, wsrc;

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_HOLD} state_type;
    state_type state_ff, nxt_state;

    assign ahb_go = hsel && hready && htrans[1];
    assign src = src_type'(ctrl_ff[CTRL_SRC +: 3]);
    assign wsrc = src_type'(hwdata[CTRL_SRC +: 3]);

    always_comb
    begin
        nxt_ctrl = ctrl_ff;
        nxt_thresh = thresh_ff;
        nxt_rate = rate_ff;
        nxt_hold = hold_ff;
        nxt_wr = ahb_go && hwrite;
        nxt_wa = ahb_go ? haddr[11:0] : wa_ff;
        nxt_rdata = 32'h0;
        if (wr_ff)
        begin
            unique case (wa_ff)
                CTRL_OFS:
                begin
                    nxt_ctrl[CTRL_SRC-1:0] = hwdata[CTRL_SRC-1:0];
                    nxt_ctrl[11:CTRL_SLOPE_NEG] = hwdata[11:CTRL_SLOPE_NEG];
                    // Keep the old source on an unusable code
                    if (wsrc <= SRC_RECOVERED && (HAS_RECOVERY || wsrc != SRC_RECOVERED))
                    begin
                        nxt_ctrl[CTRL_SRC +: 3] = hwdata[CTRL_SRC +: 3];
                    end
                    if (hwdata[CTRL_REJ +: 2] == 2'h3)
                    begin
                        nxt_ctrl[CTRL_REJ +: 2] = REJ_NONE;
                    end
                end
                THRESH_OFS: nxt_thresh = hwdata[10:0];
                RATE_OFS: nxt_rate = hwdata[23:0];
                HOLDOFF_OFS: nxt_hold = hwdata;
                default: ;
            endcase
        end
        if (ahb_go && !hwrite)
        begin
            unique case (haddr[11:0])
                CTRL_OFS: nxt_rdata = {20'h0, ctrl_ff};
                THRESH_OFS: nxt_rdata = {{21{thresh_ff[10]}}, thresh_ff};
                RATE_OFS: nxt_rdata = {8'h0, rate_ff};
                HOLDOFF_OFS: nxt_rdata = hold_ff;
                STATUS_OFS: nxt_rdata = {tcount_ff, 13'h0, self_last_ff,
                                         state_ff == ST_HOLD, state_ff == ST_ARMED};
                default: nxt_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_ff <= CTRL_RST;
            thresh_ff <= THRESH_RST;
            rate_ff <= RATE_RST;
            hold_ff <= HOLDOFF_RST;
            wr_ff <= 1'b0;
            wa_ff <= 12'h000;
            hrdata <= 32'h0;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            ctrl_ff <= nxt_ctrl;
            thresh_ff <= nxt_thresh;
            rate_ff <= nxt_rate;
            hold_ff <= nxt_hold;
            wr_ff <= nxt_wr;
            wa_ff <= nxt_wa;
            hrdata <= nxt_rdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ----------------------------------------
    // Settings decode
    // ----------------------------------------
    logic fine, direct, chan, int_sel, run, hold_evt, trig_mode;
    logic [39:0] int_ns, hold_ns;
    logic [31:0] int_cyc, hold_cyc;
    logic signed [14:0] thr_mv;
    logic [10:0] nxt_thr_out;

    assign fine = ctrl_ff[CTRL_FINE];
    assign run = ctrl_ff[CTRL_RUN];
    assign hold_evt = ctrl_ff[CTRL_HOLD_EVT];
    assign trig_mode = ctrl_ff[CTRL_TRIGGERED];
    assign chan = (src == SRC_CH1) || (src == SRC_CH2);
    assign direct = chan || (src == SRC_EXT_DIRECT);
    assign int_sel = (src == SRC_INT_CLOCK);

    always_comb
    begin
        // Fine steps are 4 ns; at 8 ns per cycle they round to whole cycles
        int_ns = fine ? {14'h0, rate_ff, 2'h0} : coarse_ns(rate_ff[5:0]);
        int_cyc = 32'((int_ns + 40'(CLK_NS / 2)) / 40'(CLK_NS));
        if (int_cyc < 32'h1)
        begin
            int_cyc = 32'h1;
        end
        else if (int_cyc > 32'(INT_MAX_CNT))
        begin
            int_cyc = 32'(INT_MAX_CNT);
        end
        hold_ns = fine ? {6'h0, hold_ff, 2'h0} : coarse_ns(hold_ff[5:0]);
        if (hold_ns / 40'(CLK_NS) > 40'(HOLD_MAX_CNT))
        begin
            hold_cyc = 32'(HOLD_MAX_CNT);
        end
        else
        begin
            hold_cyc = 32'((hold_ns + 40'(CLK_NS - 1)) / 40'(CLK_NS));
        end
        if (hold_cyc < 32'(HOLD_MIN_CYCLES))
        begin
            hold_cyc = 32'(HOLD_MIN_CYCLES);
        end
        thr_mv = fine ? 15'(signed'(thresh_ff)) : 15'(signed'(thresh_ff)) * 15'(THR_COARSE_MV);
        if (thr_mv > 15'(THR_MAX_MV))
        begin
            thr_mv = 15'(THR_MAX_MV);
        end
        else if (thr_mv < -15'(THR_MAX_MV))
        begin
            thr_mv = -15'(THR_MAX_MV);
        end
        nxt_thr_out = direct ? thr_mv[10:0] : 11'h000;
    end

    // ----------------------------------------
    // Input qualification
    // ----------------------------------------
    logic [7:0] syn;
    logic [1:0] idx;
    logic lvl, arm, lvl_d_ff, pre_d_ff, rec_d_ff, armed_lvl_ff, nxt_armed_lvl;
    logic edge_hit, arm_seen, cond_direct, cond;
    logic int_tick, int_busy, hold_tick, fire, self_fire;

    sync2 #(.W(8)) u_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d({recovered_in, prescale_in, cmp_arm, cmp_level}),
        .q(syn)
    );

    assign idx = (src == SRC_CH1) ? 2'h1 : (src == SRC_CH2) ? 2'h2 : 2'h0;
    assign lvl = syn[idx]; // high means above threshold
    assign arm = syn[3 + idx];
    assign edge_hit = slope_neg_ff ? (lvl_d_ff && !lvl) : (!lvl_d_ff && lvl);
    assign arm_seen = slope_neg_ff ? arm : !arm;
    assign cond_direct = edge_hit && (armed_lvl_ff || !hyst_on_ff);

    always_comb
    begin
        unique case (src)
            SRC_EXT_PRESCALE: cond = syn[6] && !pre_d_ff;
            SRC_INT_CLOCK: cond = int_tick;
            SRC_RECOVERED: cond = syn[7] && !rec_d_ff;
            default: cond = cond_direct;
        endcase
        // Re-arm needs the arming crossing after each accepted edge
        nxt_armed_lvl = armed_lvl_ff;
        if (cond_direct)
        begin
            nxt_armed_lvl = 1'b0;
        end
        else if (arm_seen)
        begin
            nxt_armed_lvl = 1'b1;
        end
    end

    interval_timer #(.W(32)) u_int_clk (
        .clk(hclk),
        .rst_n(hresetn),
        .enable(run && int_sel),
        .start(!int_busy),
        .repeat_en(1'b1),
        .period(int_cyc),
        .tick(int_tick),
        .busy(int_busy)
    );

    // ----------------------------------------
    // Trigger sequencing
    // ----------------------------------------
    logic [31:0] evt_ff, nxt_evt;
    logic [31:0] fr_ff, nxt_fr;

    interval_timer #(.W(32)) u_holdoff (
        .clk(hclk),
        .rst_n(hresetn),
        .enable(run),
        .start(fire && !hold_evt),
        .repeat_en(1'b0),
        .period(hold_cyc),
        .tick(hold_tick),
        .busy()
    );

    always_comb
    begin
        nxt_state = state_ff;
        nxt_evt = evt_ff;
        nxt_fr = fr_ff;
        fire = 1'b0;
        self_fire = 1'b0;
        unique case (state_ff)
            ST_IDLE:
            begin
                nxt_evt = 32'h0;
                nxt_fr = 32'h0;
                if (run)
                begin
                    nxt_state = ST_ARMED;
                end
            end
            ST_ARMED:
            begin
                nxt_fr = (fr_ff < 32'(FREERUN_CNT - 1)) ? fr_ff + 32'h1 : fr_ff;
                if (cond && (!hold_evt || evt_ff >= hold_ff))
                begin
                    fire = 1'b1;
                end
                else if (cond)
                begin
                    nxt_evt = evt_ff + 32'h1;
                end
                else if (!trig_mode && fr_ff >= 32'(FREERUN_CNT - 1))
                begin
                    fire = 1'b1;
                    self_fire = 1'b1;
                end
                if (fire)
                begin
                    nxt_evt = 32'h0;
                    nxt_fr = 32'h0;
                    nxt_state = hold_evt ? ST_ARMED : ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                if (hold_tick)
                begin
                    nxt_state = ST_ARMED;
                end
            end
        endcase
        if (!run)
        begin
            nxt_state = ST_IDLE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_ff <= ST_IDLE;
            evt_ff <= 32'h0;
            fr_ff <= 32'h0;
            lvl_d_ff <= 1'b0;
            pre_d_ff <= 1'b0;
            rec_d_ff <= 1'b0;
            armed_lvl_ff <= 1'b1;
            trig_pulse_ff <= 1'b0;
            step_pulse_ff <= 1'b0;
            self_last_ff <= 1'b0;
            tcount_ff <= 16'h0;
            threshold_mv_ff <= 11'h000;
            slope_neg_ff <= 1'b0;
            hyst_on_ff <= 1'b0;
            coupling_ac_ff <= 1'b0;
            reject_ff <= 2'h0;
        end
        else
        begin
            state_ff <= nxt_state;
            evt_ff <= nxt_evt;
            fr_ff <= nxt_fr;
            lvl_d_ff <= lvl;
            pre_d_ff <= syn[6];
            rec_d_ff <= syn[7];
            armed_lvl_ff <= nxt_armed_lvl;
            trig_pulse_ff <= fire;
            step_pulse_ff <= fire && int_sel;
            self_last_ff <= fire ? self_fire : self_last_ff;
            tcount_ff <= tcount_ff + 16'(fire);
            threshold_mv_ff <= nxt_thr_out;
            slope_neg_ff <= direct && ctrl_ff[CTRL_SLOPE_NEG];
            hyst_on_ff <= direct && !ctrl_ff[CTRL_HIGH_SENS];
            coupling_ac_ff <= chan && ctrl_ff[CTRL_AC];
            reject_ff <= chan ? ctrl_ff[CTRL_REJ +: 2] : 2'h0;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    src_legal_a: assert property (src <= SRC_RECOVERED) else $error("illegal source");
    no_self_trig_a: assert property ((trig_pulse_ff && $past(trig_mode)) |-> $past(cond))
        else $error("self trigger in triggered mode");
    freerun_bound_a: assert property (fr_ff < 32'(FREERUN_CNT))
        else $error("freerun wait overran");
    hold_quiet_a: assert property ((state_ff == ST_HOLD && $past(state_ff) == ST_HOLD)
        |-> !trig_pulse_ff) else $error("trigger during holdoff");
    step_sync_a: assert property (step_pulse_ff |-> trig_pulse_ff && $past(int_sel))
        else $error("step without trigger");
    direct_gate_a: assert property (!$past(direct) |-> threshold_mv_ff == 11'h000
        && !slope_neg_ff && !hyst_on_ff) else $error("level settings leak");
    chan_gate_a: assert property (!$past(chan) |-> !coupling_ac_ff && reject_ff == 2'h0)
        else $error("coupling settings leak");
    high_sens_a: assert property ((direct && !hyst_on_ff && edge_hit) |-> cond)
        else $error("high sensitivity edge dropped");
    evt_count_a: assert property ((state_ff == ST_ARMED && hold_evt && cond && run
        && evt_ff < hold_ff) |=> !trig_pulse_ff) else $error("early event trigger");
    int_idle_a: assert property (!(run && int_sel) |=> !int_tick)
        else $error("internal clock while unused");
    thr_range_a: assert property (signed'(threshold_mv_ff) <= 11'sd1000
        && signed'(threshold_mv_ff) >= -11'sd1000) else $error("threshold out of range");

    self_cov: cover property (fire && self_fire);
    evt_cov: cover property (fire && hold_evt && hold_ff != 32'h0);
    step_cov: cover property (step_pulse_ff);
    hold_cov: cover property (state_ff == ST_HOLD ##1 state_ff == ST_ARMED);
endmodule
`default_nettype wire

// *** sim/trig_partner.sv ***
// Model of the analog trigger comparators and the acquisition engine.
// Assumes the block's threshold and slope outputs drive the comparators.
`timescale 1ns/1ps
`default_nettype none
module trig_partner #(
    parameter int HYST_MV = 50
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic signed [11:0] sig_mv,
    input wire logic [10:0] threshold_mv_ff,
    input wire logic slope_neg_ff,
    input wire logic trig_pulse_ff,
    output logic [2:0] cmp_level,
    output logic [2:0] cmp_arm,
    output int acq_count
);
    logic signed [11:0] thr;

    // ----------------------------------------
    // Comparators: all three channels see one signal
    // ----------------------------------------
    always_comb
    begin
        thr = {threshold_mv_ff[10], threshold_mv_ff};
        cmp_level = {3{sig_mv > thr}};
        // Arming level sits on the far side of the threshold from the edge
        cmp_arm = slope_neg_ff ? {3{sig_mv > thr + 12'(HYST_MV)}}
                               : {3{sig_mv > thr - 12'(HYST_MV)}};
    end

    // Acquisition engine takes one sample per trigger pulse
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            acq_count <= 0;
        else if (trig_pulse_ff)
            acq_count <= acq_count + 1;
    end
endmodule
`default_nettype wire

// *** sim/edge_trigger_controller_test.sv ***
// Self-checking bench for the edge trigger controller.
// Assumes the partner model in trig_partner and a zero-wait slave.
`timescale 1ns/1ps
`default_nettype none
module edge_trigger_controller_test;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, in_int = 0, pre_in = 0;
    logic [31:0] haddr = 0, hwdata = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic signed [11:0] sig_mv = -12'sd200;
    wire logic hreadyout, hresp, trig_pulse_ff, step_pulse_ff, slope_neg_ff, hyst_on_ff;
    wire logic coupling_ac_ff;
    wire logic [1:0] reject_ff;
    wire logic [2:0] cmp_level, cmp_arm;
    wire logic [10:0] threshold_mv_ff;
    wire logic [31:0] hrdata;
    int acq_count, mark, miscompares = 0, n_compared = 0;

    always #4 hclk = ~hclk;

    // Short counts keep freerun and holdoff waits within a few hundred cycles
    edge_trigger_controller #(.FREERUN_CNT(50), .INT_MAX_CNT(100), .HOLD_MAX_CNT(200))
        i_edge_trigger_controller (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .cmp_level(cmp_level), .cmp_arm(cmp_arm), .prescale_in(pre_in), .recovered_in(1'b0),
        .trig_pulse_ff(trig_pulse_ff), .step_pulse_ff(step_pulse_ff),
        .threshold_mv_ff(threshold_mv_ff), .slope_neg_ff(slope_neg_ff),
        .hyst_on_ff(hyst_on_ff), .coupling_ac_ff(coupling_ac_ff), .reject_ff(reject_ff));
    trig_partner i_trig_partner (.hclk(hclk), .hresetn(hresetn), .sig_mv(sig_mv),
        .threshold_mv_ff(threshold_mv_ff), .slope_neg_ff(slope_neg_ff),
        .trig_pulse_ff(trig_pulse_ff), .cmp_level(cmp_level), .cmp_arm(cmp_arm),
        .acq_count(acq_count));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {20'h00000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        check("hresp", {31'h0, hresp}, 32'h00000000);
        r = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, d, r);
    endtask

    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        bus(a, 1'b0, 32'h00000000, r);
        check(what, r, exp);
    endtask

    task automatic stim(input logic signed [11:0] v, input int n);
        sig_mv <= v;
        repeat (n) @(posedge hclk);
    endtask

    task automatic got(input string what, input int exp);
        check(what, acq_count - mark, exp);
        mark = acq_count;
    endtask

    // Step pulses only with the internal source, always with the trigger
    always @(posedge hclk)
    begin
        if (trig_pulse_ff === 1'b1 || step_pulse_ff === 1'b1)
            check("step_pulse", {31'h0, step_pulse_ff}, {31'h0, trig_pulse_ff & in_int});
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic test_regs();
        rd("ctrl", 12'h000, 32'h00000000);
        rd("rate", 12'h008, 32'h00000002);
        rd("holdoff", 12'h00C, 32'h000000FA);
        wr(12'h020, 32'hFFFFFFFF);
        rd("unmapped", 12'h020, 32'h00000000);
        $display("test regs done");
    endtask

    task automatic test_config();
        wr(12'h000, 32'h00000604);
        wr(12'h004, 32'h000007FB);
        repeat (3) @(posedge hclk);
        check("thr_coarse", {21'h0, threshold_mv_ff}, 32'h000007CE);
        check("coupling", {31'h0, coupling_ac_ff}, 32'h00000001);
        check("reject", {30'h0, reject_ff}, 32'h00000001);
        wr(12'h000, 32'h00000602);
        repeat (3) @(posedge hclk);
        check("thr_prescale", {21'h0, threshold_mv_ff}, 32'h00000000);
        check("coupling_off", {31'h0, coupling_ac_ff}, 32'h00000000);
        check("hyst_off", {31'h0, hyst_on_ff}, 32'h00000000);
        wr(12'h000, 32'h0000060E);
        rd("src_refused", 12'h000, 32'h00000602);
        wr(12'h000, 32'h00000000);
        wr(12'h004, 32'h000000C8);
        repeat (3) @(posedge hclk);
        check("thr_clamp", {21'h0, threshold_mv_ff}, 32'h000003E8);
        $display("test config done");
    endtask

    task automatic test_hyst();
        wr(12'h004, 32'h00000064);
        wr(12'h00C, 32'h00000000);
        stim(-200, 10);
        wr(12'h000, 32'h00000141);
        mark = acq_count;
        stim(200, 20);
        got("rise", 1);
        stim(80, 200);
        stim(200, 20);
        got("not_armed", 0);
        stim(0, 20);
        stim(200, 150);
        got("rearmed", 1);
        wr(12'h000, 32'h00000151);
        mark = acq_count;
        stim(0, 20);
        got("fall", 1);
        check("slope_neg", {31'h0, slope_neg_ff}, 32'h00000001);
        stim(-200, 200);
        wr(12'h000, 32'h00000161);
        mark = acq_count;
        stim(200, 200);
        stim(80, 200);
        stim(200, 20);
        got("high_sens", 2);
        $display("test hysteresis done");
    endtask

    task automatic test_events();
        wr(12'h00C, 32'h00000002);
        stim(-200, 150);
        wr(12'h000, 32'h000001E1);
        mark = acq_count;
        repeat (6)
        begin
            stim(200, 10);
            stim(-200, 10);
        end
        got("event_holdoff", 2);
        $display("test events done");
    endtask

    task automatic test_modes();
        wr(12'h00C, 32'h00000000);
        wr(12'h000, 32'h00000101);
        mark = acq_count;
        stim(-200, 300);
        check("freerun", {31'h0, acq_count > mark}, 32'h00000001);
        wr(12'h008, 32'h0000000A);
        wr(12'h000, 32'h00000149);
        in_int <= 1'b1;
        mark = acq_count;
        stim(-200, 400);
        check("int_clock", {31'h0, acq_count > mark}, 32'h00000001);
        wr(12'h000, 32'h00000000);
        stim(-200, 10);
        in_int <= 1'b0;
        wr(12'h000, 32'h00000141);
        mark = acq_count;
        stim(-200, 400);
        got("triggered", 0);
        wr(12'h000, 32'h00000143);
        mark = acq_count;
        pre_in <= 1'b1;
        stim(-200, 10);
        pre_in <= 1'b0;
        stim(-200, 10);
        got("prescale", 1);
        $display("test modes done");
    endtask

    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_regs();
        test_config();
        test_hyst();
        test_events();
        test_modes();
        close_out();
    end

    // Whole sequence needs about 2500 cycles
    initial
    begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        close_out();
    end
endmodule
`default_nettype wire
